/* rtl/dual_8bit_timer_cascade.sv */
// Paired 8-bit timers with discrete, cascade, carrier and PWM modes
`timescale 1ns/10ps
`default_nettype none

module dual_8bit_timer_cascade (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic [15:0] i_addr,
    input wire logic i_wr_en,
    input wire logic [7:0] i_wr_data,
    input wire logic i_bit_en,
    input wire logic [2:0] i_bit_idx,
    input wire logic i_bit_val,
    input wire logic i_rd_en,
    output logic [7:0] o_rd_data,
    output logic o_match_irq_a,
    output logic o_match_irq_b,
    output logic o_timer_out_b,
    output logic o_timer_out_b_oe
);

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------

    // Byte write replaces, bit write changes one bit, mask keeps zeros
    function automatic logic [7:0] apply_write(
        input logic [7:0] old_val,
        input logic byte_we,
        input logic [7:0] wdata,
        input logic bit_we,
        input logic [2:0] idx,
        input logic bval,
        input logic [7:0] mask
    );
        logic [7:0] tmp;
        tmp = old_val;
        if (byte_we)
            tmp = wdata;
        else if (bit_we)
            tmp[idx] = bval;
        return tmp & mask;
    endfunction : apply_write

    // Joint mode decode from the three mode bits
    function automatic timer_pair_pkg::joint_mode_t decode_mode(input logic [2:0] code);
        timer_pair_pkg::joint_mode_t m;
        case (code)
            timer_pair_pkg::CODE_DISCRETE: m = timer_pair_pkg::MODE_DISCRETE;
            timer_pair_pkg::CODE_CASCADE: m = timer_pair_pkg::MODE_CASCADE;
            timer_pair_pkg::CODE_CARRIER: m = timer_pair_pkg::MODE_CARRIER;
            timer_pair_pkg::CODE_PWM: m = timer_pair_pkg::MODE_PWM;
            default: m = timer_pair_pkg::MODE_PROHIBITED;
        endcase
        return m;
    endfunction : decode_mode

    // Count enable for B from its clock select
    function automatic logic pick_tick_b(
        input logic [2:0] sel,
        input logic [timer_pair_pkg::PRESCALE_W:0] t
    );
        logic r;
        case (sel)
            timer_pair_pkg::SEL_B_FULL0: r = t[0];
            timer_pair_pkg::SEL_B_FULL1: r = t[0];
            timer_pair_pkg::SEL_B_DIV4_0: r = t[timer_pair_pkg::DIV_4];
            timer_pair_pkg::SEL_B_DIV4_1: r = t[timer_pair_pkg::DIV_4];
            timer_pair_pkg::SEL_B_DIV8: r = t[timer_pair_pkg::DIV_8];
            timer_pair_pkg::SEL_B_DIV16: r = t[timer_pair_pkg::DIV_16];
            default: r = 1'b0;
        endcase
        return r;
    endfunction : pick_tick_b

    // ----------------------------------------------------------------
    // Registers and wires
    // ----------------------------------------------------------------
    logic [7:0] mode_ctrl_a_reg;
    logic [7:0] mode_ctrl_b_reg;
    logic [7:0] compare_a_reg;
    logic [7:0] compare_b_reg;
    logic [7:0] high_width_reg;
    logic [7:0] rd_data_reg;
    logic irq_a_reg;
    logic irq_b_reg;
    logic wave_b_reg;
    logic burst_gate_reg;
    logic pin_reg;
    logic pin_oe_reg;
    logic clk_src_prev_reg;

    logic [7:0] mode_ctrl_a_next;
    logic [7:0] mode_ctrl_b_next;
    logic [7:0] rd_data_next;
    logic irq_a_next;
    logic irq_b_next;
    logic wave_b_next;
    logic burst_gate_next;
    logic pin_next;

    logic [timer_pair_pkg::PRESCALE_W:0] tick_div;
    logic [7:0] counter_a;
    logic [7:0] counter_b;
    timer_pair_pkg::joint_mode_t joint_mode;

    logic is_discrete;
    logic is_cascade;
    logic is_carrier;
    logic is_pwm;
    logic is_wave;
    logic run_a;
    logic run_b;
    logic run_a_eff;
    logic run_b_eff;
    logic out_en_b;
    logic [1:0] clk_sel_a;
    logic [2:0] clk_sel_b;
    logic eq_a;
    logic eq_b;
    logic eq_hw;
    logic joint_eq;
    logic tick_b;
    logic tick_a;
    logic tick_a_sel;
    logic wrap_a;
    logic wrap_b;
    logic match_b_pulse;
    logic match_a_pulse;
    logic clk_src;
    logic clk_src_rise;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------

    // Strobes per register
    logic we_mode_a_byte;
    logic we_mode_a_bit;
    logic we_mode_b_byte;
    logic we_mode_b_bit;
    logic we_compare_a;
    logic we_compare_b;
    logic we_high_width;

    assign we_mode_a_byte = i_wr_en && (i_addr == timer_pair_pkg::MODE_CTRL_A_ADDR);
    assign we_mode_a_bit = i_bit_en && (i_addr == timer_pair_pkg::MODE_CTRL_A_ADDR);
    assign we_mode_b_byte = i_wr_en && (i_addr == timer_pair_pkg::MODE_CTRL_B_ADDR);
    assign we_mode_b_bit = i_bit_en && (i_addr == timer_pair_pkg::MODE_CTRL_B_ADDR);
    // Compares take byte writes only; bit writes there are ignored
    assign we_compare_a = i_wr_en && (i_addr == timer_pair_pkg::COMPARE_A_ADDR);
    assign we_compare_b = i_wr_en && (i_addr == timer_pair_pkg::COMPARE_B_ADDR);
    assign we_high_width = i_wr_en && (i_addr == timer_pair_pkg::HIGH_WIDTH_ADDR);

    // Mode register next values, bit or byte granular
    assign mode_ctrl_a_next = apply_write(mode_ctrl_a_reg, we_mode_a_byte, i_wr_data,
        we_mode_a_bit, i_bit_idx, i_bit_val, timer_pair_pkg::MODE_CTRL_A_MASK);
    assign mode_ctrl_b_next = apply_write(mode_ctrl_b_reg, we_mode_b_byte, i_wr_data,
        we_mode_b_bit, i_bit_idx, i_bit_val, timer_pair_pkg::MODE_CTRL_B_MASK);

    // ----------------------------------------------------------------
    // Mode decode
    // ----------------------------------------------------------------

    // Field extraction
    assign run_a = mode_ctrl_a_reg[timer_pair_pkg::RUN_BIT];
    assign run_b = mode_ctrl_b_reg[timer_pair_pkg::RUN_BIT];
    assign out_en_b = mode_ctrl_b_reg[timer_pair_pkg::OUT_EN_B_BIT];
    assign clk_sel_a = mode_ctrl_a_reg[timer_pair_pkg::CLK_SEL_A_HI:timer_pair_pkg::CLK_SEL_A_LO];
    assign clk_sel_b = mode_ctrl_b_reg[timer_pair_pkg::CLK_SEL_B_HI:timer_pair_pkg::CLK_SEL_B_LO];

    // Joint mode from one bit of A and two bits of B
    assign joint_mode = decode_mode({mode_ctrl_a_reg[timer_pair_pkg::MODE_SEL_A_BIT],
        mode_ctrl_b_reg[timer_pair_pkg::MODE_SEL_B_HI],
        mode_ctrl_b_reg[timer_pair_pkg::MODE_SEL_B_LO]});
    assign is_discrete = (joint_mode == timer_pair_pkg::MODE_DISCRETE);
    assign is_cascade = (joint_mode == timer_pair_pkg::MODE_CASCADE);
    assign is_carrier = (joint_mode == timer_pair_pkg::MODE_CARRIER);
    assign is_pwm = (joint_mode == timer_pair_pkg::MODE_PWM);
    assign is_wave = is_carrier || is_pwm;

    // Run control: cascade ignores run A and follows run B
    assign run_a_eff = is_cascade ? run_b : (run_a && !(joint_mode == timer_pair_pkg::MODE_PROHIBITED));
    assign run_b_eff = run_b && !(joint_mode == timer_pair_pkg::MODE_PROHIBITED);

    // ----------------------------------------------------------------
    // Count clocks and compare logic
    // ----------------------------------------------------------------
    timer_prescaler #(
        .DIV_W(timer_pair_pkg::PRESCALE_W)
    ) u_prescaler (
        .i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n),
        .o_tick(tick_div)
    );

    // Continuous equality against each compare
    assign eq_a = (counter_a == compare_a_reg);
    assign eq_b = (counter_b == compare_b_reg);
    assign eq_hw = (counter_b == high_width_reg);
    assign joint_eq = eq_a && eq_b;

    assign tick_b = pick_tick_b(clk_sel_b, tick_div);

    // B wrap: own match, joint match in cascade, phase compare in wave modes
    assign wrap_b = is_cascade ? joint_eq :
                    is_wave ? (wave_b_reg ? eq_hw : eq_b) :
                    eq_b;
    assign match_b_pulse = run_b_eff && tick_b && (is_cascade ? joint_eq : eq_b);

    // Clock source for select 11: carrier in carrier mode, else B output
    assign clk_src = is_carrier ? wave_b_reg : pin_reg;
    assign clk_src_rise = clk_src && !clk_src_prev_reg;

    // Clock select for A in its own modes
    assign tick_a_sel = (clk_sel_a == timer_pair_pkg::SEL_A_DIV64) ? tick_div[timer_pair_pkg::DIV_64] :
                        (clk_sel_a == timer_pair_pkg::SEL_A_DIV256) ? tick_div[timer_pair_pkg::DIV_256] :
                        (clk_sel_a == timer_pair_pkg::SEL_A_MATCH_B) ? match_b_pulse :
                        clk_src_rise;

    // Cascade: A is the high byte, stepping on B carry or the joint clear
    assign tick_a = is_cascade ? (tick_b && ((counter_b == timer_pair_pkg::COUNT_FULL) || joint_eq)) :
                    tick_a_sel;
    assign wrap_a = is_cascade ? joint_eq : eq_a;
    assign match_a_pulse = run_a_eff && tick_a && eq_a;

    // ----------------------------------------------------------------
    // Counters
    // ----------------------------------------------------------------
    timer_counter8 #(
        .WIDTH(timer_pair_pkg::DATA_W)
    ) u_counter_a (
        .i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n),
        .i_run(run_a_eff),
        .i_tick(tick_a),
        .i_wrap(wrap_a),
        .o_count(counter_a)
    );

    timer_counter8 #(
        .WIDTH(timer_pair_pkg::DATA_W)
    ) u_counter_b (
        .i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n),
        .i_run(run_b_eff),
        .i_tick(tick_b),
        .i_wrap(wrap_b),
        .o_count(counter_b)
    );

    // ----------------------------------------------------------------
    // Interrupts, waveform and output pin
    // ----------------------------------------------------------------

    // A never interrupts in cascade; B needs the joint match there
    assign irq_a_next = match_a_pulse && !is_cascade;
    assign irq_b_next = match_b_pulse;

    // Raw B waveform: toggle on match, or low/high phases in wave modes
    always_comb
    begin
        wave_b_next = wave_b_reg;
        if (!run_b_eff)
            wave_b_next = 1'b0;
        else if (tick_b)
        begin
            if (is_wave)
            begin
                if (!wave_b_reg && eq_b)
                    wave_b_next = 1'b1;
                else if (wave_b_reg && eq_hw)
                    wave_b_next = 1'b0;
            end
            else if (is_cascade ? joint_eq : eq_b)
                wave_b_next = !wave_b_reg;
        end
    end

    // Burst gate flips on each A match in carrier mode
    assign burst_gate_next = (!is_carrier || !run_a_eff) ? 1'b0 :
                             match_a_pulse ? !burst_gate_reg : burst_gate_reg;

    // Pin: low when disabled, carrier gated by the burst in carrier mode
    assign pin_next = !out_en_b ? 1'b0 :
                      is_carrier ? (wave_b_reg && burst_gate_reg) : wave_b_reg;

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------

    // Byte reads; counters are read-only, unmapped reads zero
    assign rd_data_next = (i_addr == timer_pair_pkg::COUNTER_A_ADDR) ? counter_a :
                          (i_addr == timer_pair_pkg::COUNTER_B_ADDR) ? counter_b :
                          (i_addr == timer_pair_pkg::COMPARE_A_ADDR) ? compare_a_reg :
                          (i_addr == timer_pair_pkg::COMPARE_B_ADDR) ? compare_b_reg :
                          (i_addr == timer_pair_pkg::HIGH_WIDTH_ADDR) ? high_width_reg :
                          (i_addr == timer_pair_pkg::MODE_CTRL_A_ADDR) ? mode_ctrl_a_reg :
                          (i_addr == timer_pair_pkg::MODE_CTRL_B_ADDR) ? mode_ctrl_b_reg :
                          timer_pair_pkg::READ_UNMAPPED;

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------

    // Mode registers, cleared by reset
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            mode_ctrl_a_reg <= timer_pair_pkg::MODE_CTRL_RESET;
            mode_ctrl_b_reg <= timer_pair_pkg::MODE_CTRL_RESET;
        end
        else
        begin
            mode_ctrl_a_reg <= mode_ctrl_a_next;
            mode_ctrl_b_reg <= mode_ctrl_b_next;
        end
    end

    // Compare registers have no reset value
    always_ff @(posedge i_ref_clk)
    begin
        if (we_compare_a)
            compare_a_reg <= i_wr_data;
        if (we_compare_b)
            compare_b_reg <= i_wr_data;
        if (we_high_width)
            high_width_reg <= i_wr_data;
    end

    // Event, waveform and read state
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            irq_a_reg <= 1'b0;
            irq_b_reg <= 1'b0;
            wave_b_reg <= 1'b0;
            burst_gate_reg <= 1'b0;
            pin_reg <= 1'b0;
            pin_oe_reg <= 1'b0;
            clk_src_prev_reg <= 1'b0;
            rd_data_reg <= timer_pair_pkg::COUNT_ZERO;
        end
        else
        begin
            irq_a_reg <= irq_a_next;
            irq_b_reg <= irq_b_next;
            wave_b_reg <= wave_b_next;
            burst_gate_reg <= burst_gate_next;
            pin_reg <= pin_next;
            pin_oe_reg <= out_en_b;
            clk_src_prev_reg <= clk_src;
            if (i_rd_en)
                rd_data_reg <= rd_data_next;
        end
    end

    // Outputs straight from flip-flops
    assign o_rd_data = rd_data_reg;
    assign o_match_irq_a = irq_a_reg;
    assign o_match_irq_b = irq_b_reg;
    assign o_timer_out_b = pin_reg;
    assign o_timer_out_b_oe = pin_oe_reg;

endmodule : dual_8bit_timer_cascade
`default_nettype wire

/* rtl/timer_pair_pkg.sv */
// Constants shared by the paired 8-bit timer block
package timer_pair_pkg;

    // ----------------------------------------------------------------
    // Data path and register addresses
    // ----------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int ADDR_W = 16;
    localparam logic [15:0] COUNTER_A_ADDR = 16'hff60;
    localparam logic [15:0] COMPARE_A_ADDR = 16'hff61;
    localparam logic [15:0] MODE_CTRL_A_ADDR = 16'hff62;
    localparam logic [15:0] COUNTER_B_ADDR = 16'hff63;
    localparam logic [15:0] COMPARE_B_ADDR = 16'hff64;
    localparam logic [15:0] HIGH_WIDTH_ADDR = 16'hff65;
    localparam logic [15:0] MODE_CTRL_B_ADDR = 16'hff69;

    // ----------------------------------------------------------------
    // Field positions, write masks and reset values
    // ----------------------------------------------------------------
    localparam int RUN_BIT = 7;
    localparam int CLK_SEL_A_HI = 4;
    localparam int CLK_SEL_A_LO = 3;
    localparam int MODE_SEL_A_BIT = 1;
    localparam int CLK_SEL_B_HI = 5;
    localparam int CLK_SEL_B_LO = 3;
    localparam int MODE_SEL_B_HI = 2;
    localparam int MODE_SEL_B_LO = 1;
    localparam int OUT_EN_B_BIT = 0;
    localparam logic [7:0] MODE_CTRL_A_MASK = 8'h9a;
    localparam logic [7:0] MODE_CTRL_B_MASK = 8'hbf;
    localparam logic [7:0] MODE_CTRL_RESET = 8'h00;
    localparam logic [7:0] COUNT_ZERO = 8'h00;
    localparam logic [7:0] COUNT_FULL = 8'hff;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // ----------------------------------------------------------------
    // Joint mode codes {mode_sel_a, mode_sel_b_hi, mode_sel_b_lo}
    // ----------------------------------------------------------------
    localparam logic [2:0] CODE_DISCRETE = 3'h0;
    localparam logic [2:0] CODE_CASCADE = 3'h5;
    localparam logic [2:0] CODE_CARRIER = 3'h3;
    localparam logic [2:0] CODE_PWM = 3'h2;

    typedef enum logic [4:0] {
        MODE_DISCRETE = 5'b00001,
        MODE_CASCADE = 5'b00010,
        MODE_CARRIER = 5'b00100,
        MODE_PWM = 5'b01000,
        MODE_PROHIBITED = 5'b10000
    } joint_mode_t;

    // ----------------------------------------------------------------
    // Count clock selection
    // ----------------------------------------------------------------
    localparam int PRESCALE_W = 8;
    localparam int DIV_4 = 2;
    localparam int DIV_8 = 3;
    localparam int DIV_16 = 4;
    localparam int DIV_64 = 6;
    localparam int DIV_256 = 8;
    localparam logic [1:0] SEL_A_DIV64 = 2'h0;
    localparam logic [1:0] SEL_A_DIV256 = 2'h1;
    localparam logic [1:0] SEL_A_MATCH_B = 2'h2;
    localparam logic [1:0] SEL_A_OUT_B = 2'h3;
    localparam logic [2:0] SEL_B_FULL0 = 3'h0;
    localparam logic [2:0] SEL_B_DIV4_0 = 3'h1;
    localparam logic [2:0] SEL_B_FULL1 = 3'h2;
    localparam logic [2:0] SEL_B_DIV4_1 = 3'h3;
    localparam logic [2:0] SEL_B_DIV8 = 3'h4;
    localparam logic [2:0] SEL_B_DIV16 = 3'h5;

endpackage : timer_pair_pkg

/* rtl/timer_prescaler.sv */
// Free-running divider giving one-cycle enables at main clock over 2^k
`timescale 1ns/10ps
`default_nettype none

module timer_prescaler #(
    parameter int DIV_W = 8
) (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    output logic [DIV_W:0] o_tick
);

    logic [DIV_W-1:0] div_reg;

    // Free counter, never stopped so every rate stays in phase
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            div_reg <= '0;
        else
            div_reg <= div_reg + 1'b1;
    end

    // Divide by one is a constant enable
    assign o_tick[0] = 1'b1;

    // Divide by 2^k pulses when the low k bits are all ones
    genvar k;
    generate
        for (k = 1; k <= DIV_W; k++)
        begin : g_tick
            assign o_tick[k] = &div_reg[k-1:0];
        end
    endgenerate

endmodule : timer_prescaler
`default_nettype wire

/* rtl/timer_counter8.sv */
// One up-counter with stop-clear and wrap-to-zero on its count enable
`timescale 1ns/10ps
`default_nettype none

module timer_counter8 #(
    parameter int WIDTH = 8
) (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic i_run,
    input wire logic i_tick,
    input wire logic i_wrap,
    output logic [WIDTH-1:0] o_count
);

    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;

    // Stopped counters read zero; a wrap on a tick returns to zero
    assign count_next = !i_run ? '0 :
                        !i_tick ? count_reg :
                        i_wrap ? '0 : count_reg + 1'b1;

    // Counter storage, zero from reset
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            count_reg <= '0;
        else
            count_reg <= count_next;
    end

    assign o_count = count_reg;

endmodule : timer_counter8
`default_nettype wire

/* testbench/dual_timer_asserts.sv */
// Checker for the register port and outputs of the paired timer block
`timescale 1ns/10ps
`default_nettype none
module dual_timer_asserts (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic [15:0] i_addr,
    input wire logic i_wr_en,
    input wire logic [7:0] i_wr_data,
    input wire logic i_bit_en,
    input wire logic [2:0] i_bit_idx,
    input wire logic i_bit_val,
    input wire logic i_rd_en,
    input wire logic [7:0] o_rd_data,
    input wire logic o_match_irq_a,
    input wire logic o_match_irq_b,
    input wire logic o_timer_out_b,
    input wire logic o_timer_out_b_oe
);
    // ------------------------------------------------------------
    // Shadow copies of both mode registers
    // ------------------------------------------------------------
    logic [7:0] mode_a_reg;
    logic [7:0] mode_b_reg;
    logic zero_a_reg;
    logic zero_b_reg;
    wire sel_a = i_addr == timer_pair_pkg::MODE_CTRL_A_ADDR;
    wire sel_b = i_addr == timer_pair_pkg::MODE_CTRL_B_ADDR;
    wire quiet = !i_wr_en && !i_bit_en;
    wire zero_a = mode_a_reg[1] ? !mode_b_reg[7] : !mode_a_reg[7]; // Cascade follows run B
    wire cascade = {mode_a_reg[1], mode_b_reg[2:1]} == timer_pair_pkg::CODE_CASCADE;

    // Track writes; stop flags are delayed so the counter clear has landed
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            mode_a_reg <= 8'h00;
            mode_b_reg <= 8'h00;
            zero_a_reg <= 1'b1;
            zero_b_reg <= 1'b1;
        end
        else
        begin
            if (i_wr_en && sel_a)
                mode_a_reg <= i_wr_data;
            else if (i_bit_en && sel_a)
                mode_a_reg[i_bit_idx] <= i_bit_val;
            if (i_wr_en && sel_b)
                mode_b_reg <= i_wr_data;
            else if (i_bit_en && sel_b)
                mode_b_reg[i_bit_idx] <= i_bit_val;
            zero_a_reg <= zero_a;
            zero_b_reg <= !mode_b_reg[7];
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_reset_n);
    sequence byte_then_read;
        i_wr_en && sel_a ##1 quiet ##1 i_rd_en && sel_a && quiet;
    endsequence
    sequence bit_then_read;
        i_bit_en && !i_wr_en && sel_a ##1 quiet ##1 i_rd_en && sel_a && quiet;
    endsequence
    a_read_data_holds: assert property (!i_rd_en |=> $stable(o_rd_data))
        else $error("read data changed without a read");
    a_unmapped_reads_zero: assert property (i_rd_en && !(i_addr inside {16'hff60, 16'hff61,
        16'hff62, 16'hff63, 16'hff64, 16'hff65, 16'hff69}) |=> o_rd_data == 8'h00)
        else $error("unmapped read not zero");
    a_mode_a_byte: assert property (byte_then_read |=>
        o_rd_data == ($past(i_wr_data, 3) & timer_pair_pkg::MODE_CTRL_A_MASK))
        else $error("mode A byte write readback wrong");
    a_mode_a_bit: assert property (bit_then_read |=> o_rd_data[$past(i_bit_idx, 3)] ==
        ($past(i_bit_val, 3) && timer_pair_pkg::MODE_CTRL_A_MASK[$past(i_bit_idx, 3)]))
        else $error("mode A bit write readback wrong");
    a_out_enable_follows: assert property ((i_wr_en && sel_b) ##1 quiet |=>
        o_timer_out_b_oe == $past(i_wr_data[0], 2))
        else $error("output enable does not follow write");
    a_stopped_a_zero: assert property (i_rd_en && i_addr == timer_pair_pkg::COUNTER_A_ADDR
        && zero_a && zero_a_reg |=> o_rd_data == timer_pair_pkg::COUNT_ZERO)
        else $error("stopped counter A not zero");
    a_stopped_b_zero: assert property (i_rd_en && i_addr == timer_pair_pkg::COUNTER_B_ADDR
        && !mode_b_reg[7] && zero_b_reg |=> o_rd_data == timer_pair_pkg::COUNT_ZERO)
        else $error("stopped counter B not zero");
    a_cascade_no_irq_a: assert property (cascade && $past(cascade) |-> !o_match_irq_a)
        else $error("interrupt A raised in cascade mode");
endmodule : dual_timer_asserts
`default_nettype wire

/* testbench/dual_8bit_timer_cascade_tb_top.sv */
// Self-checking bench for the paired 8-bit timer block
`timescale 1ns/10ps
`default_nettype none
module dual_8bit_timer_cascade_tb_top;
    logic i_ref_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic [15:0] i_addr = 16'h0000;
    logic i_wr_en = 1'b0;
    logic [7:0] i_wr_data = 8'h00;
    logic i_bit_en = 1'b0;
    logic [2:0] i_bit_idx = 3'h0;
    logic i_bit_val = 1'b0;
    logic i_rd_en = 1'b0;
    wire [7:0] o_rd_data;
    wire o_match_irq_a;
    wire o_match_irq_b;
    wire o_timer_out_b;
    wire o_timer_out_b_oe;
    int n_errors = 0;
    int n_checks = 0;
    int n_irq_a = 0;
    int div_a [4] = '{64, 256, 3, 6};

    dual_8bit_timer_cascade dut (.*);
    always #5 i_ref_clk = ~i_ref_clk;
    always @(negedge i_ref_clk) n_irq_a += (o_match_irq_a === 1'b1);

    // ------------------------------------------------------------
    // Bus cycles and comparisons
    // ------------------------------------------------------------
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input bit bit_w = 0);
        i_addr = a;
        i_wr_data = d;
        i_bit_idx = d[2:0];
        i_bit_val = d[7];
        i_wr_en = !bit_w;
        i_bit_en = bit_w;
        @(negedge i_ref_clk);
        i_wr_en = 1'b0;
        i_bit_en = 1'b0;
        @(negedge i_ref_clk);
    endtask : wr
    task automatic expect_reg(input logic [15:0] a, input logic [7:0] exp);
        i_addr = a;
        i_rd_en = 1'b1;
        @(negedge i_ref_clk);
        i_rd_en = 1'b0;
        @(negedge i_ref_clk);
        n_checks++;
        if (o_rd_data !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: reg %h expected %h got %h", $time, a, exp, o_rd_data);
        end
    endtask : expect_reg
    // Cycles between interrupt pulses (w 0 or 1) or width of a high pin phase (w 2)
    function automatic logic pick(input int w);
        return w == 0 ? o_match_irq_a : (w == 1 ? o_match_irq_b : o_timer_out_b);
    endfunction : pick
    task automatic expect_span(input int w, input int exp);
        int n;
        n = 0;
        while (pick(w) === 1'b1 && n < 2000) @(negedge i_ref_clk) n++;
        while (pick(w) !== 1'b1 && n < 2000) @(negedge i_ref_clk) n++;
        n = 0;
        do @(negedge i_ref_clk) n++; while ((w == 2) == (pick(w) === 1'b1) && n < 2000);
        n_checks++;
        if (n != exp)
        begin
            n_errors++;
            $display("unexpected at %0t: span expected %h got %h", $time, exp, n);
        end
    endtask : expect_span
    task automatic expect_num(input int exp, input int got);
        n_checks++;
        if (got != exp)
        begin
            n_errors++;
            $display("unexpected at %0t: count expected %h got %h", $time, exp, got);
        end
    endtask : expect_num

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_registers;
        expect_reg(16'hff60, 8'h00);
        expect_reg(16'hff63, 8'h00);
        expect_reg(16'hff62, 8'h00);
        expect_reg(16'hff66, 8'h00);
        wr(16'hff62, 8'hff);
        expect_reg(16'hff62, 8'h9a);
        wr(16'hff62, 8'h07, 1);
        expect_reg(16'hff62, 8'h1a);
        wr(16'hff62, 8'h86, 1);
        expect_reg(16'hff62, 8'h1a);
        wr(16'hff62, 8'h00);
        wr(16'hff60, 8'h55);
        expect_reg(16'hff60, 8'h00);
    endtask : test_registers
    task automatic test_discrete;
        wr(16'hff64, 8'h02);
        wr(16'hff69, 8'h81);
        expect_span(1, 3);
        expect_span(2, 3);
        for (int s = 0; s < 4; s++)
        begin
            wr(16'hff62, 8'h00);
            wr(16'hff61, 8'h01);
            wr(16'hff62, 8'h80 | (s << 3));
            expect_span(0, 2 * div_a[s]);
        end
        wr(16'hff62, 8'h00);
        wr(16'hff69, 8'h00);
        @(negedge i_ref_clk);
        expect_reg(16'hff63, 8'h00);
        expect_reg(16'hff60, 8'h00);
    endtask : test_discrete
    task automatic test_cascade;
        int seen;
        wr(16'hff61, 8'h01);
        wr(16'hff64, 8'h02);
        wr(16'hff62, 8'h02);
        wr(16'hff69, 8'h82);
        seen = n_irq_a;
        expect_span(1, 259);
        expect_span(1, 259);
        expect_num(seen, n_irq_a);
        wr(16'hff69, 8'h00);
        @(negedge i_ref_clk);
        expect_reg(16'hff60, 8'h00);
        wr(16'hff62, 8'h00);
    endtask : test_cascade
    task automatic test_pwm;
        wr(16'hff64, 8'h03);
        wr(16'hff65, 8'h01);
        wr(16'hff69, 8'h85);
        expect_span(2, 2);
        expect_span(1, 6);
        wr(16'hff69, 8'h00);
    endtask : test_pwm
    task automatic test_carrier;
        int seen = 0;
        wr(16'hff62, 8'h90);
        wr(16'hff69, 8'h87);
        repeat (48) @(negedge i_ref_clk) seen += (o_timer_out_b === 1'b1);
        expect_num(8, seen);
    endtask : test_carrier

    // ------------------------------------------------------------
    // Sequence, verdict and watchdog
    // ------------------------------------------------------------
    task automatic test_done;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done
    initial
    begin
        repeat (5) @(negedge i_ref_clk);
        i_reset_n = 1'b1;
        @(negedge i_ref_clk);
        test_registers();
        test_discrete();
        test_cascade();
        test_pwm();
        test_carrier();
        test_done();
    end
    initial
    begin
        #300000;
        n_errors++;
        test_done();
    end
endmodule : dual_8bit_timer_cascade_tb_top
bind dual_8bit_timer_cascade dual_timer_asserts u_chk (.*);
`default_nettype wire
